// ===== rtl/tgr_timer_unit.sv
`timescale 1ns/1ps
// Operation
// [RL1] Gate mode: count internal events only while input pin is high.
// [RL2] Retrigger mode: input rising edge zeroes count and restarts cycle.
// [RL3] Outside clock select: input edges clock the timer; retrigger ignored.
// [RL4] Retrigger mode waits for first rising edge after enabling.
// [RL5] Retrigger keeps compare-select flag, extending current compare phase.
// [RL6] Output changes one clock after the slot reaching maximum count.
// [RL7] Single compare: output low one clock at compare A match.
// [RL8] Dual compare: output low while B used, high while A used.
// [RL9] Output returns high at end of each counting sequence.
// [RL10] External clock to output delay spans 2.5 to 6.5 clocks; the logic gives 3 to 7.
// [RL11] Disabled timer does not increment in its slot.
// [RL12] Write guard decides whether a control write changes enable.
// [RL13] Without continuous run, enable self-clears at sequence end.
// [RL14] Outside driver holds gate levels at least four clocks.
// [RL15] One shared interrupt request; timer 0 highest, timer 2 lowest.
// [RL16] Interrupt requested at each maximum count when enabled.
// [RL17] Clearing interrupt enable does not cancel a latched request.
// [RL18] Second request before service replaces rather than queues.
// [RL19] Count reads and writes are synchronised with servicing.
// [RL20] Outside inputs toggle no faster than quarter CPU clock.
// [RL21] Count equal to compare resets to zero in same step.
// [RL22] Dual compare alternates counting to A then to B.
// [RL23] Max count flag sets at maximum, cleared by control write.
// [RL24] Internal clocking increments once every fourth clock slot.
// [RL25] Compare-select flag toggles each maximum; output follows next clock; the logic toggles it in dual compare mode only.
module tgr_timer_unit
    import tgr_pkg::*;
#(
    parameter int NUM_TIMERS = tgr_pkg::TGR_NUM_TIMERS,
    parameter int CNT_W = tgr_pkg::TGR_CNT_W
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Timer pins; timer 2 has none, so each port has entries for timers 0 and 1 only.
    input wire logic [1:0] timer_input_pin,
    output logic [1:0] timer_output_pin,
    // Control write port, one strobe per timer.
    input wire logic [NUM_TIMERS-1:0] ctl_wr,
    input wire logic [tgr_pkg::TGR_CTL_W-1:0] ctl_wdata,
    // Count and compare writes, one strobe per timer.
    input wire logic [NUM_TIMERS-1:0] cnt_wr,
    input wire logic [NUM_TIMERS-1:0] cmpa_wr,
    input wire logic [NUM_TIMERS-1:0] cmpb_wr,
    input wire logic [CNT_W-1:0] wdata,
    // Count read, selected by index.
    input wire logic [1:0] cnt_rd_sel,
    output logic [CNT_W-1:0] cnt_rdata,
    // Status per timer.
    output logic [NUM_TIMERS-1:0] enable_bit,
    output logic [NUM_TIMERS-1:0] max_count_flag,
    output logic [NUM_TIMERS-1:0] compare_select_flag,
    // Interrupt controller interface.
    input wire logic [NUM_TIMERS-1:0] irq_ack,
    output logic [NUM_TIMERS-1:0] irq_pending,
    output logic timer_irq,
    output logic [1:0] irq_timer_id
);
    import tgr_pkg::*;

    initial begin
        if (NUM_TIMERS != 3 || CNT_W < 2) begin
            $error("tgr_timer_unit: only three timers of at least 2 bits are supported");
        end
    end

    logic [1:0] slot_q;
    logic [CNT_W-1:0] cnt_q [NUM_TIMERS];
    logic [CNT_W-1:0] cmpa_q [NUM_TIMERS];
    logic [CNT_W-1:0] cmpb_q [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] en_q;
    logic [NUM_TIMERS-1:0] continuous_run_bit_q;
    logic [NUM_TIMERS-1:0] dual_q;
    logic [NUM_TIMERS-1:0] rtg_q;
    logic [NUM_TIMERS-1:0] ext_q;
    logic [NUM_TIMERS-1:0] ie_q;
    logic [NUM_TIMERS-1:0] mc_q;
    logic [NUM_TIMERS-1:0] sel_q;
    logic [NUM_TIMERS-1:0] irq_q;
    tgr_state_t st_q [NUM_TIMERS];
    logic [1:0] out_q;
    logic [1:0] pin_lvl;
    logic [1:0] pin_rise;
    logic [1:0] edge_pend_q;
    logic [1:0] rtg_pend_q;
    logic [NUM_TIMERS-1:0] hit;
    logic [NUM_TIMERS-1:0] serv;

    // True for the timers that have pins (timers 0 and 1).
    function automatic logic has_pins(input int t);
        has_pins = (t < 2);
    endfunction : has_pins

    // Pin synchronisers for timers 0 and 1.
    for (genvar g = 0; g < 2; g++) begin : g_sync
        tgr_sync u_sync (
            .sys_clk(sys_clk),
            .rst(rst),
            .pin_async(timer_input_pin[g]),
            .pin_level(pin_lvl[g]),
            .pin_rise(pin_rise[g])
        );
    end

    // Slot counter; each timer owns one slot in every four clocks.
    // [RL24] Four-clock servicing.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slot_q <= TGR_SLOT_RST;
        end else begin
            slot_q <= slot_q + 2'h1;
        end
    end

    // Service decision and maximum-count detection per timer.
    always_comb begin
        for (int t = 0; t < NUM_TIMERS; t++) begin
            serv[t] = 1'b0;
            hit[t] = 1'b0;
            if (slot_q == t[1:0] && en_q[t] && st_q[t] == TGR_ST_RUN) begin
                // [RL11] Disabled means no increment.
                if (has_pins(t) && ext_q[t]) begin
                    // [RL3] Pin edge as clock.
                    serv[t] = edge_pend_q[t[0]];
                end else if (has_pins(t) && !rtg_q[t]) begin
                    // [RL1] Level gate.
                    serv[t] = pin_lvl[t[0]];
                end else begin
                    serv[t] = 1'b1;
                end
            end
            // [RL21] Compare of zero means full range.
            if (serv[t]) begin
                hit[t] = (cnt_q[t] + 1'b1) ==
                    ((dual_q[t] && sel_q[t]) ? cmpb_q[t] : cmpa_q[t]);
            end
        end
    end

    // Pending external edges and retriggers, consumed in the timer's slot.
    // Latching edges here gives a 3 to 7 clock input to output delay, against the 2.5 to 6.5 of [RL10].
    // [RL10] Edge held until serviced.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_pend_q <= 2'h0;
            rtg_pend_q <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (pin_rise[p]) begin
                    edge_pend_q[p] <= 1'b1;
                    rtg_pend_q[p] <= 1'b1;
                end else if (slot_q == p[1:0]) begin
                    edge_pend_q[p] <= 1'b0;
                    rtg_pend_q[p] <= 1'b0;
                end
            end
        end
    end

    // Count, compare registers, modes and state. Software writes land in any
    // clock; the count changes only here, so a read never sees a torn value.
    // [RL19] Synchronised access.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
                cnt_q[t] <= TGR_CNT_RST;
                cmpa_q[t] <= TGR_CNT_RST;
                cmpb_q[t] <= TGR_CNT_RST;
                st_q[t] <= TGR_ST_IDLE;
            end
            en_q <= '0;
            continuous_run_bit_q <= '0;
            dual_q <= '0;
            rtg_q <= '0;
            ext_q <= '0;
            ie_q <= '0;
            mc_q <= '0;
            sel_q <= '0;
        end else begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (cmpa_wr[t]) begin
                    cmpa_q[t] <= wdata;
                end
                if (cmpb_wr[t] && has_pins(t)) begin
                    cmpb_q[t] <= wdata;
                end
                if (cnt_wr[t]) begin
                    cnt_q[t] <= wdata;
                end else if (has_pins(t) && rtg_q[t] && !ext_q[t] && en_q[t]
                             && slot_q == t[1:0] && rtg_pend_q[t[0]]) begin
                    // [RL2] Retrigger zeroes count.
                    // [RL5] Compare-select kept.
                    cnt_q[t] <= '0;
                    st_q[t] <= TGR_ST_RUN;
                end else if (hit[t]) begin
                    cnt_q[t] <= '0;
                end else if (serv[t]) begin
                    cnt_q[t] <= cnt_q[t] + 1'b1;
                end
                if (ctl_wr[t]) begin
                    // [RL12] Enable write guard.
                    if (ctl_wdata[TGR_CTL_GUARD]) begin
                        en_q[t] <= ctl_wdata[TGR_CTL_EN];
                        // [RL4] Retrigger waits for edge.
                        st_q[t] <= (has_pins(t) && ctl_wdata[TGR_CTL_RTG]
                                    && !ctl_wdata[TGR_CTL_EXT]) ? TGR_ST_WAIT : TGR_ST_RUN;
                    end
                    continuous_run_bit_q[t] <= ctl_wdata[TGR_CTL_CONTINUOUS_RUN_BIT];
                    dual_q[t] <= ctl_wdata[TGR_CTL_DUAL] & has_pins(t);
                    rtg_q[t] <= ctl_wdata[TGR_CTL_RTG] & has_pins(t);
                    ext_q[t] <= ctl_wdata[TGR_CTL_EXT] & has_pins(t);
                    ie_q[t] <= ctl_wdata[TGR_CTL_IE];
                end
                // [RL23] Flag set wins over clear.
                if (hit[t]) begin
                    mc_q[t] <= 1'b1;
                end else if (ctl_wr[t] && ctl_wdata[TGR_CTL_MCCLR]) begin
                    mc_q[t] <= 1'b0;
                end
                if (hit[t]) begin
                    // [RL22] Alternate A and B.
                    // [RL25] Toggle compare select.
                    if (dual_q[t]) begin
                        sel_q[t] <= ~sel_q[t];
                    end
                    // [RL13] Self-disable at sequence end.
                    if (!continuous_run_bit_q[t] && (!dual_q[t] || sel_q[t])) begin
                        en_q[t] <= 1'b0;
                    end
                end
            end
        end
    end

    // Output pins, registered so they change one clock after the hit slot.
    // [RL6] One clock after maximum.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_q <= {2{TGR_OUT_RST}};
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (dual_q[p]) begin
                    // [RL8] Low while B in use.
                    // [RL9] High at sequence end.
                    out_q[p] <= hit[p] ? sel_q[p] : ~sel_q[p];
                end else begin
                    // [RL7] One-clock low pulse.
                    out_q[p] <= ~hit[p];
                end
            end
        end
    end

    // Interrupt latches; a repeat request merges into the pending one.
    // [RL16] Request at each maximum.
    // [RL17] Latched past enable clear.
    // [RL18] No queueing.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= '0;
        end else begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (hit[t] && ie_q[t]) begin
                    irq_q[t] <= 1'b1;
                end else if (irq_ack[t]) begin
                    irq_q[t] <= 1'b0;
                end
            end
        end
    end

    // Shared request and fixed priority, lowest index first.
    // [RL15] Shared request with priority.
    always_comb begin
        irq_timer_id = 2'h0;
        if (!irq_q[0] && irq_q[1]) begin
            irq_timer_id = 2'h1;
        end else if (!irq_q[0] && !irq_q[1] && irq_q[2]) begin
            irq_timer_id = 2'h2;
        end
    end

    assign timer_irq = |irq_q;
    assign irq_pending = irq_q;
    assign timer_output_pin = out_q;
    assign enable_bit = en_q;
    assign max_count_flag = mc_q;
    assign compare_select_flag = sel_q;
    assign cnt_rdata = (cnt_rd_sel < 2'h3) ? cnt_q[cnt_rd_sel] : '0;
endmodule : tgr_timer_unit

// ===== rtl/tgr_pkg.sv
package tgr_pkg;

    // Number of timers and count width.
    localparam int TGR_NUM_TIMERS = 3;
    localparam int TGR_CNT_W = 16;

    // Each timer is serviced once every four CPU clocks.
    localparam int TGR_SLOT_PERIOD = 4;
    localparam logic [1:0] TGR_SLOT_RST = 2'h0;

    // Reset values of the per-timer state.
    localparam logic [15:0] TGR_CNT_RST = 16'h0000;
    localparam logic TGR_EN_RST = 1'b0;
    localparam logic TGR_OUT_RST = 1'b1;

    // Control bit positions of the write word (per timer control port).
    localparam int TGR_CTL_EN = 0;
    localparam int TGR_CTL_GUARD = 1;
    localparam int TGR_CTL_CONTINUOUS_RUN_BIT = 2;
    localparam int TGR_CTL_DUAL = 3;
    localparam int TGR_CTL_RTG = 4;
    localparam int TGR_CTL_EXT = 5;
    localparam int TGR_CTL_IE = 6;
    localparam int TGR_CTL_MCCLR = 7;
    localparam int TGR_CTL_W = 8;

    // Per-timer sequencing state.
    typedef enum logic [2:0] {
        TGR_ST_IDLE = 3'b001,
        TGR_ST_WAIT = 3'b010,
        TGR_ST_RUN = 3'b100
    } tgr_state_t;

endpackage : tgr_pkg

// ===== rtl/tgr_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser followed by a rising edge detector on the synced level.
module tgr_sync (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Asynchronous pin and its synchronised views.
    input wire logic pin_async,
    output logic pin_level,
    output logic pin_rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // The first flop feeds only the second one, keeping metastability contained.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Level and edge are both taken from the second flop.
    assign pin_level = sync_q;
    assign pin_rise = sync_q & ~prev_q;
endmodule : tgr_sync

// ===== verif/tgr_pin_model.sv
`timescale 1ns/1ps
// Drives the timer input pins, never changing a level sooner than allowed.
module tgr_pin_model (
    // Clock.
    input wire logic sys_clk,
    // Requested and driven pin levels.
    input wire logic [1:0] pin_req,
    output logic [1:0] pin_out
);
    logic [2:0] hold [2] = '{3'h0, 3'h0};
    initial pin_out = 2'h0;
    // Fast toggles would be lost by the slot scan, so each level is held.
    // minimum level hold
    always @(negedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (pin_req[i] != pin_out[i] && hold[i] >= 3'h4) begin
                pin_out[i] <= pin_req[i];
                hold[i] <= 3'h1;
            end else if (hold[i] < 3'h4) begin
                hold[i] <= hold[i] + 3'h1;
            end
        end
    end
endmodule : tgr_pin_model

// ===== verif/tgr_timer_unit_checker.sv
`timescale 1ns/1ps
// Watches timer 0 and the interrupt outputs of the timer unit.
module tgr_timer_unit_checker
    import tgr_pkg::*;
#(
    parameter int NUM_TIMERS = 3,
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports.
    input wire logic [1:0] timer_output_pin,
    input wire logic [NUM_TIMERS-1:0] ctl_wr,
    input wire logic [tgr_pkg::TGR_CTL_W-1:0] ctl_wdata,
    input wire logic [NUM_TIMERS-1:0] cnt_wr,
    input wire logic [1:0] cnt_rd_sel,
    input wire logic [CNT_W-1:0] cnt_rdata,
    input wire logic [NUM_TIMERS-1:0] enable_bit,
    input wire logic [NUM_TIMERS-1:0] max_count_flag,
    input wire logic [NUM_TIMERS-1:0] compare_select_flag,
    input wire logic [NUM_TIMERS-1:0] irq_ack,
    input wire logic [NUM_TIMERS-1:0] irq_pending,
    input wire logic timer_irq,
    input wire logic [1:0] irq_timer_id
);
    logic [1:0] slot_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Mirror of the service slot so count moves can be placed in time.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slot_q <= TGR_SLOT_RST;
        end else begin
            slot_q <= slot_q + 2'h1;
        end
    end
    AST_SLOT_ONLY: assert property (
        cnt_rd_sel == 2'h0 && $stable(cnt_rd_sel) && !$past(cnt_wr[0]) && $past(slot_q) != 2'h0
        |-> $stable(cnt_rdata)) else $error("count moved outside its slot");
    AST_PULSE_ONE: assert property (
        $fell(timer_output_pin[0]) && !compare_select_flag[0] |=> timer_output_pin[0])
        else $error("single pulse not one clock");
    AST_SEL_AT_MAX: assert property (
        $changed(compare_select_flag[0]) |-> max_count_flag[0] || $past(ctl_wr[0]))
        else $error("select flag moved without max count");
    AST_EN_GUARD: assert property (
        $rose(enable_bit[0]) |-> $past(ctl_wr[0]) && $past(ctl_wdata[TGR_CTL_GUARD]))
        else $error("enable set without guarded write");
    AST_EN_SELF: assert property (
        $fell(enable_bit[0]) |-> $past(ctl_wr[0]) || max_count_flag[0])
        else $error("enable cleared without cause");
    AST_MC_HOLD: assert property (
        $fell(max_count_flag[0]) |-> $past(ctl_wr[0])) else $error("max flag lost");
    AST_IRQ_SRC: assert property (
        $rose(irq_pending[0]) |-> max_count_flag[0]) else $error("request without max count");
    AST_IRQ_HOLD: assert property (
        $fell(irq_pending[0]) |-> $past(irq_ack[0])) else $error("request dropped unserviced");
    AST_IRQ_OR: assert property (
        timer_irq == |irq_pending) else $error("shared request wrong");
    AST_IRQ_PRIO: assert property (
        timer_irq |-> irq_timer_id == (irq_pending[0] ? 2'h0 : irq_pending[1] ? 2'h1 : 2'h2))
        else $error("priority wrong");
    COV_PULSE: cover property ($fell(timer_output_pin[0]) && !compare_select_flag[0]);
    COV_BOTH: cover property (irq_pending[0] && irq_pending[2]);
    COV_SELF: cover property ($fell(enable_bit[0]) && !$past(ctl_wr[0]));
endmodule : tgr_timer_unit_checker
bind tgr_timer_unit tgr_timer_unit_checker #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .timer_output_pin(timer_output_pin), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .cnt_wr(cnt_wr), .cnt_rd_sel(cnt_rd_sel), .cnt_rdata(cnt_rdata),
    .enable_bit(enable_bit), .max_count_flag(max_count_flag), .irq_ack(irq_ack),
    .compare_select_flag(compare_select_flag), .irq_pending(irq_pending),
    .timer_irq(timer_irq), .irq_timer_id(irq_timer_id));

// ===== verif/timer_gate_retrigger_output_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) check(n, 32'(e), 32'(s));
module timer_gate_retrigger_output_test;
    import tgr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] pin_req = 2'h0, cnt_rd_sel = 2'h0, pin, out, irq_id;
    logic [2:0] ctl_wr = 3'h0, cnt_wr = 3'h0, cmpa_wr = 3'h0, cmpb_wr = 3'h0, irq_ack = 3'h0;
    logic [2:0] en, mcf, csf, irq_pend;
    logic [7:0] ctl_wdata = 8'h00;
    logic [15:0] wdata = 16'h0000, cnt_rdata, c, d;
    logic irq;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    // The clock; inputs change on its falling edge.
    initial forever #5 sys_clk = ~sys_clk;
    tgr_pin_model u_tgr_pin_model (.sys_clk(sys_clk), .pin_req(pin_req), .pin_out(pin));
    tgr_timer_unit u_tgr_timer_unit (.sys_clk(sys_clk), .rst(rst), .timer_input_pin(pin),
        .timer_output_pin(out), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .cnt_wr(cnt_wr),
        .cmpa_wr(cmpa_wr), .cmpb_wr(cmpb_wr), .wdata(wdata), .cnt_rd_sel(cnt_rd_sel),
        .cnt_rdata(cnt_rdata), .enable_bit(en), .max_count_flag(mcf), .irq_ack(irq_ack),
        .compare_select_flag(csf), .irq_pending(irq_pend), .timer_irq(irq),
        .irq_timer_id(irq_id));
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %0h seen %0h", nm, e, s);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : tick
    // Kind 0 count, 1 compare A, 2 compare B, 3 control; strobe lasts one clock.
    task automatic wr(input int k, input int t, input logic [15:0] v);
        wdata = v;
        ctl_wdata = v[7:0];
        case (k)
            0: cnt_wr[t] = 1'b1;
            1: cmpa_wr[t] = 1'b1;
            2: cmpb_wr[t] = 1'b1;
            default: ctl_wr[t] = 1'b1;
        endcase
        tick(1);
        {ctl_wr, cnt_wr, cmpa_wr, cmpb_wr} = 12'h000;
        tick(1);
    endtask : wr
    task automatic rd(input int t, output logic [15:0] v);
        cnt_rd_sel = 2'(t);
        #1;
        v = cnt_rdata;
    endtask : rd
    task automatic ack(input int t);
        irq_ack[t] = 1'b1;
        tick(1);
        irq_ack[t] = 1'b0;
        tick(1);
    endtask : ack
    // Bounded wait for a max count flag; the clocks spent come back in n.
    task automatic wait_mc(input int t);
        n = 0;
        while (mcf[t] !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        if (n >= 200) begin
            error_cnt++;
            close_out();
        end
    endtask : wait_mc
    task automatic sc_single;
        pin_req <= 2'h3;
        tick(8);
        wr(1, 0, 16'h0003);
        wr(0, 0, 16'h0000);
        wr(3, 0, 16'h0043);
        wait_mc(0);
        `CHK("oneshot_time", 1, n >= 7 && n <= 12)
        tick(2);
        rd(0, c);
        `CHK("oneshot_cnt", 0, c)
        `CHK("oneshot_en", 0, en[0])
        `CHK("oneshot_out", 1, out[0])
        `CHK("oneshot_irq", 3'h1, irq_pend)
        wr(3, 0, 16'h0080);
        `CHK("ie_off_irq", 1, irq)
        `CHK("mc_clear", 0, mcf[0])
        ack(0);
    endtask : sc_single
    task automatic sc_gate;
        pin_req <= 2'h0;
        tick(8);
        wr(1, 0, 16'h0000);
        wr(0, 0, 16'h0000);
        wr(3, 0, 16'h0007);
        tick(40);
        rd(0, c);
        `CHK("gate_low", 0, c)
        pin_req <= 2'h1;
        tick(6);
        rd(0, c);
        tick(40);
        rd(0, d);
        `CHK("gate_high", 10, d - c)
        wr(3, 0, 16'h0004);
        `CHK("guard_off", 1, en[0])
        wr(3, 0, 16'h0006);
        rd(0, c);
        tick(20);
        rd(0, d);
        `CHK("disabled", c, d)
    endtask : sc_gate
    task automatic sc_retrig;
        pin_req <= 2'h0;
        wr(1, 1, 16'h0000);
        wr(0, 1, 16'h0000);
        wr(3, 1, 16'h0017);
        tick(40);
        rd(1, c);
        `CHK("rtg_wait", 0, c)
        pin_req <= 2'h2;
        tick(40);
        pin_req <= 2'h0;
        tick(8);
        pin_req <= 2'h2;
        // The pin model lags a clock and the edge waits for its slot, so allow ten clocks.
        tick(10);
        rd(1, d);
        `CHK("rtg_reset", 1, d < 16'h0003)
    endtask : sc_retrig
    task automatic sc_dual;
        pin_req <= 2'h3;
        wr(1, 0, 16'h0002);
        wr(2, 0, 16'h0003);
        wr(0, 0, 16'h0000);
        wr(1, 2, 16'h0001);
        wr(3, 2, 16'h0043);
        wr(3, 0, 16'h004f);
        wait_mc(0);
        tick(2);
        `CHK("dual_b", 2'h1, {out[0], csf[0]})
        `CHK("prio_0", 0, irq_id)
        ack(0);
        `CHK("prio_2", 2, irq_id)
        ack(2);
        wr(3, 0, 16'h00cc);
        wait_mc(0);
        tick(2);
        `CHK("dual_a", 2'h2, {out[0], csf[0]})
        `CHK("dual_b_irq", 1, irq_pend[0])
    endtask : sc_dual
    task automatic sc_ext;
        pin_req <= 2'h0;
        wr(3, 1, 16'h0002);
        wr(1, 1, 16'h0002);
        wr(0, 1, 16'h0000);
        wr(3, 1, 16'h0037);
        tick(20);
        pin_req <= 2'h2;
        n = 0;
        c = 16'h0000;
        while (c !== 16'h0001 && n < 12) begin
            tick(1);
            n++;
            rd(1, c);
        end
        `CHK("ext_delay", 1, n >= 3 && n <= 8)
        pin_req <= 2'h0;
        tick(8);
        pin_req <= 2'h2;
        tick(10);
        rd(1, c);
        `CHK("ext_max", 2'h2, {mcf[1], c[0]})
    endtask : sc_ext
    // Reset for eight clocks, then the scenarios in turn.
    initial begin
        tick(8);
        rst = 1'b0;
        sc_single();
        sc_gate();
        sc_retrig();
        sc_dual();
        sc_ext();
        close_out();
    end
endmodule : timer_gate_retrigger_output_test
